// File: psp_pkg.sv
// Package: register map, field positions and reset values of the slave port
package psp_pkg;
  // Register byte offsets on APB (word aligned)
  localparam logic [11:0] OFF_CTRL      = 12'h000;
  localparam logic [11:0] OFF_CTRL_PORT = 12'h004;
  localparam logic [11:0] OFF_CTRL_LAT  = 12'h008;
  localparam logic [11:0] OFF_ANALOG    = 12'h00c;
  localparam logic [11:0] OFF_DATA_PORT = 12'h010;
  localparam logic [11:0] OFF_DATA_LAT  = 12'h014;
  localparam logic [11:0] OFF_DATA_DIR  = 12'h018;
  localparam logic [11:0] OFF_FLAG      = 12'h01c;
  localparam logic [11:0] OFF_ENABLE    = 12'h020;
  localparam logic [11:0] OFF_PRIO      = 12'h024;
  localparam logic [11:0] OFF_IRQ_STAT  = 12'h028;
  localparam logic [11:0] OFF_IRQ_EN    = 12'h02c;
  localparam logic [11:0] OFF_IRQ_CLR   = 12'h030;
  // Control register fields and the peripheral flag bit
  localparam int BIT_IN_PEND   = 7;
  localparam int BIT_OUT_PEND  = 6;
  localparam int BIT_OVERRUN   = 5;
  localparam int BIT_PORT_SEL  = 4;
  localparam int BIT_RESERVED  = 3;
  localparam int BIT_PSP_FLAG  = 7;
  // Event status bits
  localparam int EV_HOST_WR = 0;
  localparam int EV_HOST_RD = 1;
  localparam int EV_OVERRUN = 2;
  // Reset values and the digital analog-config pattern
  localparam logic [7:0] RST_CTRL     = 8'h07;
  localparam logic [7:0] RST_ZERO     = 8'h00;
  localparam logic [7:0] RST_DATA_DIR = 8'hff;
  localparam logic [7:0] ANALOG_DIGITAL = 8'h07;
endpackage : psp_pkg

// File: psp_sync.sv
// Two-flop synchroniser for a bundle of pin inputs
`timescale 1ns/100ps
module psp_sync #(
  parameter int W = 11
) (
  input  wire logic         clk,
  input  wire logic         srst,
  input  wire logic         ce,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);
  logic [W-1:0] meta_reg;

  // First stage feeds only the second stage
  always_ff @(posedge clk) begin
    if (srst) begin
      meta_reg <= '1;
      sync_out <= '1;
    end else if (ce) begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end
endmodule : psp_sync

// File: psp_top.sv
// Parallel slave port with APB register access and interrupt logic
`timescale 1ns/100ps
// Functional notes
// - Bit 4 selects slave-port mode
// - Input pending set on unread host write
// - Output pending until host reads word
// - Overrun set on write over unread; software clears
// - Bits 2..0 are control pin directions
// - Bit 3 reads zero, writes ignored
// - Read strobe active low when selected
// - Write strobe active low when selected
// - Chip select active low, gates strobes
// - Host write taken at first low detect
// - Host read taken at first low detect
// - Pins 0,1,2 become read, write, select
// - Needs input directions and digital config
// - Host sees one byte-wide data latch
// - Strobes synchronised before any use
module psp_top (
  input  wire logic        clk,
  input  wire logic        srst,
  input  wire logic        ce,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [7:0]  data_port_in,
  output logic      [7:0]  data_port_out,
  output logic      [7:0]  data_port_oe,
  input  wire logic [2:0]  control_port_in,
  output logic      [2:0]  control_port_out,
  output logic      [2:0]  control_port_oe,
  output logic             irq,
  output logic             periph_irq_high,
  output logic             periph_irq_low
);

  ////////////////////////////////////////////////////////////////////////
  // Registers
  logic [7:0] ctrl_reg;        // pending flags, mode, directions
  logic [2:0] ctrl_lat_reg;
  logic [7:0] analog_config_reg;
  logic [7:0] data_in_reg;     // word written by host
  logic [7:0] data_port_latch;
  logic [7:0] data_port_dir;
  logic [7:0] periph_flag_reg;
  logic [7:0] periph_enable_reg;
  logic [7:0] periph_priority_reg;
  logic [2:0] irq_stat_reg;
  logic [2:0] irq_en_reg;
  logic       rd_active_reg;
  logic       wr_active_reg;
  logic [10:0] pins_sync;

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisation
  psp_sync #(.W(11)) u_sync (
    .clk      (clk),
    .srst     (srst),
    .ce       (ce),
    .async_in ({control_port_in, data_port_in}),
    .sync_out (pins_sync)
  );

  logic [7:0] data_pins;
  logic       ctrl_pin0;
  logic       ctrl_pin1;
  logic       ctrl_pin2;
  logic       slave_port_select;
  logic       ctrl_inputs_ok;
  logic       host_sel;
  logic       host_rd_low;
  logic       host_wr_low;
  logic       host_rd_evt;
  logic       host_wr_evt;

  assign data_pins = pins_sync[7:0];
  assign ctrl_pin0 = pins_sync[8];
  assign ctrl_pin1 = pins_sync[9];
  assign ctrl_pin2 = pins_sync[10];
  assign slave_port_select = ctrl_reg[psp_pkg::BIT_PORT_SEL];
  // Strobes only mean something with input pins in digital mode
  assign ctrl_inputs_ok = (ctrl_reg[2:0] == 3'h7) &&
    (analog_config_reg[2:0] == psp_pkg::ANALOG_DIGITAL[2:0]);
  assign host_sel = slave_port_select && ctrl_inputs_ok && !ctrl_pin2;
  assign host_rd_low = host_sel && !ctrl_pin0;
  assign host_wr_low = host_sel && !ctrl_pin1;
  // First detection only; a held strobe counts once
  assign host_rd_evt = host_rd_low && !rd_active_reg;
  assign host_wr_evt = host_wr_low && !wr_active_reg;

  // Strobe history for first-detect edges
  always_ff @(posedge clk) begin
    if (srst) begin
      rd_active_reg <= 1'b0;
      wr_active_reg <= 1'b0;
    end else if (ce) begin
      rd_active_reg <= host_rd_low;
      wr_active_reg <= host_wr_low;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // APB decode
  logic        apb_wr;
  logic        apb_rd;
  logic        addr_hit;
  logic [31:0] rd_mux;

  assign apb_wr = psel && penable && pwrite && ce;
  assign apb_rd = psel && penable && !pwrite && ce;

  function automatic logic hit(input logic [11:0] a, input logic [11:0] o);
    hit = (a == o);
  endfunction : hit

  always_comb begin
    addr_hit = 1'b1;
    rd_mux   = 32'h0000_0000;
    case (paddr)
      psp_pkg::OFF_CTRL:      rd_mux[7:0] = ctrl_reg &
        ~(8'h01 << psp_pkg::BIT_RESERVED);
      psp_pkg::OFF_CTRL_PORT: rd_mux[2:0] = slave_port_select ?
        3'h0 : {ctrl_pin2, ctrl_pin1, ctrl_pin0};
      psp_pkg::OFF_CTRL_LAT:  rd_mux[2:0] = ctrl_lat_reg;
      psp_pkg::OFF_ANALOG:    rd_mux[7:0] = analog_config_reg;
      // In port mode the CPU sees the host's word, else the pins
      psp_pkg::OFF_DATA_PORT: rd_mux[7:0] = slave_port_select ?
        data_in_reg : data_pins;
      psp_pkg::OFF_DATA_LAT:  rd_mux[7:0] = data_port_latch;
      psp_pkg::OFF_DATA_DIR:  rd_mux[7:0] = data_port_dir;
      psp_pkg::OFF_FLAG:      rd_mux[7:0] = periph_flag_reg;
      psp_pkg::OFF_ENABLE:    rd_mux[7:0] = periph_enable_reg;
      psp_pkg::OFF_PRIO:      rd_mux[7:0] = periph_priority_reg;
      psp_pkg::OFF_IRQ_STAT:  rd_mux[2:0] = irq_stat_reg;
      psp_pkg::OFF_IRQ_EN:    rd_mux[2:0] = irq_en_reg;
      psp_pkg::OFF_IRQ_CLR:   rd_mux = 32'h0000_0000;
      default:                addr_hit = 1'b0;
    endcase
  end

  // Zero wait state answer; unmapped addresses flag an error
  always_ff @(posedge clk) begin
    if (srst) begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else if (ce) begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable && !addr_hit;
      if (psel && !penable && !pwrite) begin
        prdata <= rd_mux;
      end
    end
  end

  // Access completes on the cycle pready is high
  logic acc_wr;
  logic acc_rd;
  assign acc_wr = apb_wr && pready;
  assign acc_rd = apb_rd && pready;

  logic cpu_data_rd;
  logic cpu_data_wr;
  assign cpu_data_rd = acc_rd && hit(paddr, psp_pkg::OFF_DATA_PORT);
  assign cpu_data_wr = acc_wr && (hit(paddr, psp_pkg::OFF_DATA_PORT) ||
                                  hit(paddr, psp_pkg::OFF_DATA_LAT));

  ////////////////////////////////////////////////////////////////////////
  // Control register: flags set by hardware win over clears
  always_ff @(posedge clk) begin
    if (srst) begin
      ctrl_reg <= psp_pkg::RST_CTRL;
    end else if (ce) begin
      if (acc_wr && hit(paddr, psp_pkg::OFF_CTRL)) begin
        ctrl_reg[psp_pkg::BIT_PORT_SEL] <= pwdata[psp_pkg::BIT_PORT_SEL];
        ctrl_reg[2:0] <= pwdata[2:0];
        // Overrun clears only by writing zero
        if (!pwdata[psp_pkg::BIT_OVERRUN]) begin
          ctrl_reg[psp_pkg::BIT_OVERRUN] <= 1'b0;
        end
      end
      ctrl_reg[psp_pkg::BIT_RESERVED] <= 1'b0;
      // Input pending
      if (host_wr_evt) begin
        ctrl_reg[psp_pkg::BIT_IN_PEND] <= 1'b1;
      end else if (cpu_data_rd && slave_port_select) begin
        ctrl_reg[psp_pkg::BIT_IN_PEND] <= 1'b0;
      end
      if (host_wr_evt && ctrl_reg[psp_pkg::BIT_IN_PEND]) begin
        ctrl_reg[psp_pkg::BIT_OVERRUN] <= 1'b1;
      end
      // Output pending: CPU write sets, host read clears
      if (cpu_data_wr && slave_port_select) begin
        ctrl_reg[psp_pkg::BIT_OUT_PEND] <= 1'b1;
      end else if (host_rd_evt) begin
        ctrl_reg[psp_pkg::BIT_OUT_PEND] <= 1'b0;
      end
    end
  end

  // Host write captures the data bus into the input latch
  always_ff @(posedge clk) begin
    if (srst) begin
      data_in_reg <= psp_pkg::RST_ZERO;
    end else if (ce && host_wr_evt) begin
      data_in_reg <= data_pins;
    end
  end

  // Plain software registers
  always_ff @(posedge clk) begin
    if (srst) begin
      ctrl_lat_reg        <= 3'h0;
      analog_config_reg   <= psp_pkg::RST_ZERO;
      data_port_latch     <= psp_pkg::RST_ZERO;
      data_port_dir       <= psp_pkg::RST_DATA_DIR;
      periph_enable_reg   <= psp_pkg::RST_ZERO;
      periph_priority_reg <= psp_pkg::RST_ZERO;
      irq_en_reg          <= 3'h0;
    end else if (ce && acc_wr) begin
      if (hit(paddr, psp_pkg::OFF_CTRL_PORT) ||
          hit(paddr, psp_pkg::OFF_CTRL_LAT)) begin
        ctrl_lat_reg <= pwdata[2:0];
      end
      if (hit(paddr, psp_pkg::OFF_ANALOG)) begin
        analog_config_reg <= pwdata[7:0];
      end
      if (cpu_data_wr) begin
        data_port_latch <= pwdata[7:0];
      end
      if (hit(paddr, psp_pkg::OFF_DATA_DIR)) begin
        data_port_dir <= pwdata[7:0];
      end
      if (hit(paddr, psp_pkg::OFF_ENABLE)) begin
        periph_enable_reg <= pwdata[7:0];
      end
      if (hit(paddr, psp_pkg::OFF_PRIO)) begin
        periph_priority_reg <= pwdata[7:0];
      end
      if (hit(paddr, psp_pkg::OFF_IRQ_EN)) begin
        irq_en_reg <= pwdata[2:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Peripheral flag: each host read or write sets it at first strobe detect
  always_ff @(posedge clk) begin
    if (srst) begin
      periph_flag_reg <= psp_pkg::RST_ZERO;
    end else if (ce) begin
      if (acc_wr && hit(paddr, psp_pkg::OFF_FLAG)) begin
        periph_flag_reg <= pwdata[7:0];
      end
      if (host_wr_evt || host_rd_evt) begin
        periph_flag_reg[psp_pkg::BIT_PSP_FLAG] <= 1'b1;
      end
    end
  end

  // Sticky event status; write-one clear loses to a new event
  always_ff @(posedge clk) begin
    if (srst) begin
      irq_stat_reg <= 3'h0;
    end else if (ce) begin
      irq_stat_reg <= (irq_stat_reg &
        ~((acc_wr && hit(paddr, psp_pkg::OFF_IRQ_CLR)) ? pwdata[2:0] : 3'h0))
        | {host_wr_evt && ctrl_reg[psp_pkg::BIT_IN_PEND],
           host_rd_evt, host_wr_evt};
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs, all registered
  logic psp_int;
  assign psp_int = periph_flag_reg[psp_pkg::BIT_PSP_FLAG] &&
                   periph_enable_reg[psp_pkg::BIT_PSP_FLAG];

  always_ff @(posedge clk) begin
    if (srst) begin
      irq              <= 1'b0;
      periph_irq_high  <= 1'b0;
      periph_irq_low   <= 1'b0;
      data_port_out    <= psp_pkg::RST_ZERO;
      data_port_oe     <= psp_pkg::RST_ZERO;
      control_port_out <= 3'h0;
      control_port_oe  <= 3'h0;
    end else if (ce) begin
      irq <= |(irq_stat_reg & irq_en_reg);
      // Priority bit routes the port interrupt
      periph_irq_high <= psp_int &&
        periph_priority_reg[psp_pkg::BIT_PSP_FLAG];
      periph_irq_low  <= psp_int &&
        !periph_priority_reg[psp_pkg::BIT_PSP_FLAG];
      data_port_out <= data_port_latch;
      // Slave mode drives the bus only while host reads
      data_port_oe <= slave_port_select ? {8{host_rd_low}} :
                      ~data_port_dir;
      control_port_out <= ctrl_lat_reg;
      control_port_oe  <= slave_port_select ? 3'h0 : ~ctrl_reg[2:0];
    end
  end
endmodule : psp_top

// File: psp_properties.sv
// Concurrent checks on the slave port top-level ports
`timescale 1ns/100ps
module psp_properties (
  input wire logic        clk,
  input wire logic        srst,
  input wire logic        ce,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [2:0]  control_port_in,
  input wire logic [7:0]  data_port_oe,
  input wire logic        irq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  ////////////////////////////////////////////////////////////////////////////
  // Bus setup cycle and a host that keeps its read strobe high
  sequence setup_s;
    psel && !penable && ce;
  endsequence
  sequence rd_idle_s;
    control_port_in[0] [*5];
  endsequence
  // Fixed one-cycle answer; the bench master still polls for pready
  setup_ready_a: assert property (setup_s |=> pready)
    else $error("no ready after setup");
  ready_access_a: assert property (pready |-> psel && penable)
    else $error("ready outside access");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  // Mapped words are aligned and run contiguously up to the clear register
  err_map_a: assert property (pready |->
    pslverr == (paddr[1:0] != 2'b00 || paddr > psp_pkg::OFF_IRQ_CLR))
    else $error("error flag wrong for address");
  err_data_a: assert property (pslverr && !pwrite |-> prdata == 32'h0000_0000)
    else $error("unmapped read not zero");
  // Read data only moves at a read setup
  rdata_hold_a: assert property (
    !(psel && !penable && ce && !pwrite) |=> $stable(prdata))
    else $error("read data moved");
  reset_quiet_a: assert property ($fell(srst) |-> !irq && !pready && !pslverr)
    else $error("outputs not quiet after reset");
  // Synchroniser delay is short, so five idle samples must stop driving
  rd_release_a: assert property (rd_idle_s |-> !(&data_port_oe))
    else $error("data bus driven without read");
endmodule : psp_properties

bind psp_top psp_properties i_psp_properties (.clk(clk), .srst(srst),
  .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .control_port_in(control_port_in), .data_port_oe(data_port_oe), .irq(irq));

// File: psp_host.sv
// Behavioural external microprocessor on the slave port pins
`timescale 1ns/100ps
module psp_host (
  input  wire logic       clk,
  input  wire logic [7:0] data_port_out,
  input  wire logic [7:0] data_port_oe,
  input  wire logic [2:0] control_port_out,
  input  wire logic [2:0] control_port_oe,
  output logic      [7:0] data_port_in,
  output logic      [2:0] control_port_in
);
  logic [2:0] strobe_n = 3'b111;
  logic [7:0] bus_q    = 8'h00;
  logic [7:0] float_q  = 8'h5a;
  logic       drive    = 1'b0;
  ////////////////////////////////////////////////////////////////////////////
  // Floating bus changes every cycle so no stale value can pass
  always @(posedge clk) float_q <= ~float_q;
  // Wire levels from every driver's enable
  assign data_port_in = (data_port_oe & data_port_out) |
                        (~data_port_oe & (drive ? bus_q : float_q));
  assign control_port_in = (control_port_oe & control_port_out) |
                           (~control_port_oe & strobe_n);
  // One host access: pattern is {select, write, read}, all active low
  task automatic cycle(input logic [2:0] pat, input logic [7:0] d,
                       input int hold, output logic [7:0] q);
    bus_q <= d;
    drive <= !pat[1];
    strobe_n <= pat;
    repeat (hold) @(posedge clk);
    q = data_port_in;
    strobe_n <= 3'b111;
    @(posedge clk);
    drive <= 1'b0;
    repeat (3) @(posedge clk);
  endtask : cycle
endmodule : psp_host

// File: testbench.sv
// Self-checking bench for the parallel slave port
`timescale 1ns/100ps
module testbench;
  logic        clk = 1'b0;
  logic        srst = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata, q;
  logic        pready, pslverr, slv, irq, irq_hi, irq_lo;
  logic [7:0]  dp_in, dp_out, dp_oe, hq;
  logic [2:0]  cp_in, cp_out, cp_oe;
  int          err_count = 0;
  int          compares = 0;
  int          cycles = 0;
  psp_top i_psp_top (.clk(clk), .srst(srst), .ce(1'b1), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .data_port_in(dp_in), .data_port_out(dp_out), .data_port_oe(dp_oe),
    .control_port_in(cp_in), .control_port_out(cp_out),
    .control_port_oe(cp_oe), .irq(irq), .periph_irq_high(irq_hi),
    .periph_irq_low(irq_lo));
  psp_host i_psp_host (.clk(clk), .data_port_out(dp_out),
    .data_port_oe(dp_oe), .control_port_out(cp_out),
    .control_port_oe(cp_oe), .data_port_in(dp_in), .control_port_in(cp_in));
  ////////////////////////////////////////////////////////////////////////////
  // One APB transfer; the global timeout bounds the wait
  task automatic apb(input logic [11:0] a, input logic w, input logic [7:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h00_0000, d};
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    q = prdata;
    slv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb
  task automatic check(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
    compares++;
    if (g !== e) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask : check
  task automatic rd_chk(input logic [11:0] a, input logic [7:0] e);
    apb(a, 1'b0, 8'h00);
    check($sformatf("reg %h", a), {24'h00_0000, e}, q);
  endtask : rd_chk
  ////////////////////////////////////////////////////////////////////////////
  // Reset values, reserved bit, unmapped address
  task automatic t_regs;
    rd_chk(psp_pkg::OFF_CTRL, 8'h07);
    rd_chk(psp_pkg::OFF_DATA_DIR, 8'hff);
    rd_chk(psp_pkg::OFF_FLAG, 8'h00);
    rd_chk(psp_pkg::OFF_IRQ_STAT, 8'h00);
    apb(psp_pkg::OFF_CTRL, 1'b1, 8'hff);
    rd_chk(psp_pkg::OFF_CTRL, 8'h17);
    apb(12'h100, 1'b0, 8'h00);
    check("unmapped err", 1, slv);
    check("unmapped data", 0, q);
    // Plain port mode: direction bits and latches reach the pins
    apb(psp_pkg::OFF_CTRL, 1'b1, 8'h00);
    apb(psp_pkg::OFF_CTRL_LAT, 1'b1, 8'h05);
    apb(psp_pkg::OFF_DATA_DIR, 1'b1, 8'h0f);
    apb(psp_pkg::OFF_DATA_LAT, 1'b1, 8'h96);
    // Output flops follow the registers one edge later
    @(posedge clk);
    check("ctrl oe", 3'h7, cp_oe);
    check("ctrl out", 3'h5, cp_out);
    check("data oe", 8'hf0, dp_oe);
    check("data out", 8'h96, dp_out);
    apb(psp_pkg::OFF_DATA_DIR, 1'b1, 8'hff);
    apb(psp_pkg::OFF_CTRL, 1'b1, 8'h17);
  endtask : t_regs
  // Host strobes ignored without digital pins, mode or select
  task automatic t_ignore;
    i_psp_host.cycle(3'b001, 8'h11, 6, hq);
    apb(psp_pkg::OFF_ANALOG, 1'b1, psp_pkg::ANALOG_DIGITAL);
    apb(psp_pkg::OFF_CTRL, 1'b1, 8'h07);
    i_psp_host.cycle(3'b001, 8'h22, 6, hq);
    apb(psp_pkg::OFF_CTRL, 1'b1, 8'h17);
    i_psp_host.cycle(3'b101, 8'h33, 6, hq);
    rd_chk(psp_pkg::OFF_IRQ_STAT, 8'h00);
    check("ctrl oe slave", 0, cp_oe);
  endtask : t_ignore
  // Host writes, pending flag, overrun, peripheral interrupt routing
  task automatic t_host_wr;
    apb(psp_pkg::OFF_IRQ_EN, 1'b1, 8'h07);
    apb(psp_pkg::OFF_ENABLE, 1'b1, 8'h80);
    apb(psp_pkg::OFF_PRIO, 1'b1, 8'h80);
    i_psp_host.cycle(3'b001, 8'ha5, 6, hq);
    rd_chk(psp_pkg::OFF_CTRL, 8'h97);
    check("irq", 1, irq);
    check("irq high", 1, irq_hi);
    check("irq low", 0, irq_lo);
    rd_chk(psp_pkg::OFF_FLAG, 8'h80);
    rd_chk(psp_pkg::OFF_DATA_PORT, 8'ha5);
    rd_chk(psp_pkg::OFF_CTRL, 8'h17);
    i_psp_host.cycle(3'b001, 8'h5a, 3, hq);
    i_psp_host.cycle(3'b001, 8'hc3, 10, hq);
    apb(psp_pkg::OFF_CTRL, 1'b1, 8'h37);
    rd_chk(psp_pkg::OFF_CTRL, 8'hb7);
    rd_chk(psp_pkg::OFF_DATA_PORT, 8'hc3);
    apb(psp_pkg::OFF_CTRL, 1'b1, 8'h17);
    rd_chk(psp_pkg::OFF_CTRL, 8'h17);
  endtask : t_host_wr
  // Host read of the CPU byte, then interrupt mask and clear
  task automatic t_host_rd;
    apb(psp_pkg::OFF_IRQ_CLR, 1'b1, 8'h07);
    apb(psp_pkg::OFF_DATA_LAT, 1'b1, 8'h3c);
    rd_chk(psp_pkg::OFF_CTRL, 8'h57);
    i_psp_host.cycle(3'b010, 8'h00, 10, hq);
    check("host byte", 8'h3c, hq);
    rd_chk(psp_pkg::OFF_CTRL, 8'h17);
    rd_chk(psp_pkg::OFF_IRQ_STAT, 8'h02);
    apb(psp_pkg::OFF_IRQ_EN, 1'b1, 8'h01);
    apb(psp_pkg::OFF_PRIO, 1'b1, 8'h00);
    // Interrupt outputs are registered: let one more edge pass
    @(posedge clk);
    check("masked irq", 0, irq);
    check("irq low routed", 1, irq_lo);
    check("irq high routed", 0, irq_hi);
    apb(psp_pkg::OFF_IRQ_CLR, 1'b1, 8'h02);
    rd_chk(psp_pkg::OFF_IRQ_STAT, 8'h00);
  endtask : t_host_rd
  task automatic end_sim;
    $display("compares %0d err_count %0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : end_sim
  ////////////////////////////////////////////////////////////////////////////
  // Clock, hang guard and main sequence
  initial forever #5 clk = ~clk;
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      err_count++;
      end_sim;
    end
  end
  initial begin
    repeat (6) @(posedge clk);
    srst <= 1'b0;
    t_regs;
    t_ignore;
    t_host_wr;
    t_host_rd;
    end_sim;
  end
endmodule : testbench
